// ### verilog/sbt_params.svh
// Constants of the boundary scan test port: instruction codes, widths, reset values.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
`define SBT_IR_W         3
`define SBT_IR_EXTEST    3'h0
`define SBT_IR_IDCODE    3'h1
`define SBT_IR_SAMPLE_Z  3'h2
`define SBT_IR_PRELOAD   3'h4
`define SBT_IR_BYPASS    3'h7
`define SBT_IR_CAPTURE   2'h1
`define SBT_ID_W         32
`define SBT_ID_CODE      32'h1234_5001
`define SBT_BSR_PINS     8
`define SBT_BSR_FILL     2
`define SBT_BSR_W        10
`define SBT_TLR_ONES     5
`endif

// ### verilog/sbt_pkg.sv
// Types shared by the test port modules.
// Assumes the constants header is on the include path.
`include "sbt_params.svh"
package sbt_pkg;
  typedef enum logic [3:0] {
    SBT_TLR   = 4'hF,
    SBT_RTI   = 4'hC,
    SBT_SELDR = 4'h7,
    SBT_CAPDR = 4'h6,
    SBT_SHDR  = 4'h2,
    SBT_EX1DR = 4'h1,
    SBT_PDR   = 4'h3,
    SBT_EX2DR = 4'h0,
    SBT_UPDR  = 4'h5,
    SBT_SELIR = 4'h4,
    SBT_CAPIR = 4'hE,
    SBT_SHIR  = 4'hA,
    SBT_EX1IR = 4'h9,
    SBT_PIR   = 4'hB,
    SBT_EX2IR = 4'h8,
    SBT_UPIR  = 4'hD
  } sbt_state_e;
endpackage : sbt_pkg

// ### verilog/sbt_ctl_if.sv
// Carries the controller state from the state machine to the data path.
// Assumes both ends run on the test clock.
`timescale 1ns/1ps
`default_nettype none
interface sbt_ctl_if;
  import sbt_pkg::*;
  sbt_state_e state;
  modport fsm (output state);
  modport dp  (input state);
endinterface : sbt_ctl_if
`default_nettype wire

// ### verilog/sbt_fsm.sv
// Sixteen-state test access port controller.
// Assumes the test clock and power-up reset; mode select already sampled on its clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_fsm
  import sbt_pkg::*;
(
  input  wire logic i_tck,
  input  wire logic i_rst_b,
  input  wire logic i_tms,
  sbt_ctl_if.fsm    ctl
);
  sbt_state_e state_q;
  sbt_state_e state_d;

  always_comb
  begin
    case (state_q)
      SBT_TLR:   state_d = i_tms ? SBT_TLR   : SBT_RTI;   // [R21]
      SBT_RTI:   state_d = i_tms ? SBT_SELDR : SBT_RTI;
      SBT_SELDR: state_d = i_tms ? SBT_SELIR : SBT_CAPDR;
      SBT_CAPDR: state_d = i_tms ? SBT_EX1DR : SBT_SHDR;
      SBT_SHDR:  state_d = i_tms ? SBT_EX1DR : SBT_SHDR;
      SBT_EX1DR: state_d = i_tms ? SBT_UPDR  : SBT_PDR;
      SBT_PDR:   state_d = i_tms ? SBT_EX2DR : SBT_PDR;
      SBT_EX2DR: state_d = i_tms ? SBT_UPDR  : SBT_SHDR;
      SBT_UPDR:  state_d = i_tms ? SBT_SELDR : SBT_RTI;
      SBT_SELIR: state_d = i_tms ? SBT_TLR   : SBT_CAPIR; // [R5]
      SBT_CAPIR: state_d = i_tms ? SBT_EX1IR : SBT_SHIR;
      SBT_SHIR:  state_d = i_tms ? SBT_EX1IR : SBT_SHIR;
      SBT_EX1IR: state_d = i_tms ? SBT_UPIR  : SBT_PIR;
      SBT_PIR:   state_d = i_tms ? SBT_EX2IR : SBT_PIR;
      SBT_EX2IR: state_d = i_tms ? SBT_UPIR  : SBT_SHIR;
      SBT_UPIR:  state_d = i_tms ? SBT_SELDR : SBT_RTI;
      default:   state_d = SBT_TLR;
    endcase
  end

  always_ff @(posedge i_tck or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_q <= SBT_TLR; // [R6]
    else
      state_q <= state_d; // [R2]
  end

  assign ctl.state = state_q;
endmodule : sbt_fsm
`default_nettype wire

// ### verilog/sbt_tap.sv
// Boundary scan test port of the memory: data registers, instruction and serial output.
// Assumes the controller drives the test clock; the memory core sits outside.
//
// What this block does
// [R1] Sample inputs rising edge, outputs change falling edge.
// [R2] Mode select steers state machine; undriven reads one.
// [R3] Serial input feeds selected register; undriven reads one.
// [R4] Serial output driven only in shift states.
// [R5] Five high mode select edges reach reset state.
// [R6] Power-up reset; idle while test clock stops.
// [R7] Controller selects registers by mode select sequences.
// [R8] Registers capture rising edge, shift out falling.
// [R9] Three-bit instruction, loaded only when selected.
// [R10] Reset state presets identification instruction.
// [R11] Bypass is one flip-flop between input, output.
// [R12] Boundary chain captures pins; fillers hold one.
// [R13] Boundary chain selected by three sampling instructions.
// [R14] Identification instruction captures fixed 32-bit code.
// [R15] Identification shifts out bit zero first.
// [R16] Capture-IR loads low instruction bits 01.
// [R17] Shift-IR shifts new in, old out.
// [R18] New instruction takes effect at Update-IR.
// [R19] Codes: extest 000, id 001, sample-z 010, preload 100, bypass 111.
// [R20] Sample-z forces memory outputs to high impedance.
// [R21] Standard sixteen-state controller, mode select only.
// [R22] Private codes select the bypass register.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap
  import sbt_pkg::*;
(
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_ce,
  input  wire logic                    i_tck,
  input  wire logic                    i_tms,
  input  wire logic                    i_tdi,
  input  wire logic [`SBT_BSR_PINS-1:0] i_pins,
  output logic                         o_tdo,
  output logic                         o_tdo_oe,
  output logic                         o_mem_out_hiz,
  output logic                         o_extest,
  output logic [`SBT_BSR_PINS-1:0]     o_bsr_drive
);
  sbt_ctl_if ctl ();

  // Pins pulled up outside; an open line arrives here as one.
  sbt_fsm u_fsm (
    .i_tck   (i_tck),
    .i_rst_b (i_rst_b),
    .i_tms   (i_tms),  // [R2]
    .ctl     (ctl)
  );

  sbt_state_e st;
  assign st = ctl.state;

  logic [`SBT_IR_W-1:0]  ir_shift_q;
  logic [`SBT_IR_W-1:0]  ir_q;
  logic                  byp_q;
  logic [`SBT_ID_W-1:0]  id_q;
  logic [`SBT_BSR_W-1:0] bsr_q;
  logic [`SBT_BSR_PINS-1:0] bsr_upd_q;
  logic                  tdo_q;
  logic                  tdo_oe_q;

  function automatic logic sel_bsr(input logic [`SBT_IR_W-1:0] ir);
    sel_bsr = (ir == `SBT_IR_EXTEST) || (ir == `SBT_IR_SAMPLE_Z) ||
              (ir == `SBT_IR_PRELOAD); // [R13]
  endfunction : sel_bsr

  wire is_id   = (ir_q == `SBT_IR_IDCODE);  // [R14]
  wire is_bsr  = sel_bsr(ir_q);
  // Everything else, private codes included, falls to bypass.
  wire is_byp  = !is_id && !is_bsr;         // [R22]
  wire cap_dr  = (st == SBT_CAPDR);
  wire sh_dr   = (st == SBT_SHDR);
  wire sh_ir   = (st == SBT_SHIR);
  wire dr_out  = is_id ? id_q[0] : (is_bsr ? bsr_q[0] : byp_q); // [R15]
  wire ser_out = sh_ir ? ir_shift_q[0] : dr_out;
  wire [`SBT_BSR_W-1:0] bsr_cap = {{`SBT_BSR_FILL{1'b1}}, i_pins}; // [R12]

  // Rising-edge data path of the test clock.
  always_ff @(posedge i_tck or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ir_shift_q <= `SBT_IR_IDCODE;
      ir_q       <= `SBT_IR_IDCODE; // [R10]
      byp_q      <= 1'b0;
      id_q       <= `SBT_ID_CODE;
      bsr_q      <= {`SBT_BSR_W{1'b1}};
      bsr_upd_q  <= '0;
    end
    else
    begin
      if (st == SBT_TLR)
        ir_q <= `SBT_IR_IDCODE; // [R10]
      else if (st == SBT_UPIR)
        ir_q <= ir_shift_q; // [R18]
      if (st == SBT_CAPIR)
        ir_shift_q <= {ir_q[`SBT_IR_W-1:2], `SBT_IR_CAPTURE}; // [R16]
      else if (sh_ir)
        ir_shift_q <= {i_tdi, ir_shift_q[`SBT_IR_W-1:1]}; // [R17] [R9] [R3]
      if (cap_dr && is_byp)
        byp_q <= 1'b0;
      else if (sh_dr && is_byp)
        byp_q <= i_tdi; // [R11]
      if (cap_dr && is_id)
        id_q <= `SBT_ID_CODE; // [R14]
      else if (sh_dr && is_id)
        id_q <= {i_tdi, id_q[`SBT_ID_W-1:1]}; // [R15]
      if (cap_dr && is_bsr)
        bsr_q <= bsr_cap; // [R12]
      else if (sh_dr && is_bsr)
        bsr_q <= {i_tdi, bsr_q[`SBT_BSR_W-1:1]}; // [R8]
      if (st == SBT_UPDR && is_bsr)
        bsr_upd_q <= bsr_q[`SBT_BSR_PINS-1:0];
    end
  end

  // Serial output moves on the falling edge so the far end samples it stable.
  always_ff @(negedge i_tck or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tdo_q    <= 1'b1;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_q    <= ser_out;        // [R1] [R8]
      tdo_oe_q <= sh_dr || sh_ir; // [R4]
    end
  end

  // Memory-side controls are synchronised onto the reference clock.
  logic [1:0] hiz_s_q;
  logic [1:0] ext_s_q;
  logic [2:0] upd_s_q;
  logic       hiz_q;
  logic       ext_q;
  logic       hiz_src_q;
  logic       ext_src_q;
  logic       upd_tgl_q;
  logic [`SBT_BSR_PINS-1:0] drv_q;
  wire        ir_hiz = (ir_q == `SBT_IR_SAMPLE_Z); // [R20]
  wire        ir_ext = (ir_q == `SBT_IR_EXTEST);

  // Decodes are registered on the test clock so that only glitch-free single bits cross.
  // The update stage announces a new word by a toggle; the word is stable long before
  // the toggle has passed the synchroniser.
  always_ff @(posedge i_tck or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hiz_src_q <= 1'b0;
      ext_src_q <= 1'b0;
      upd_tgl_q <= 1'b0;
    end
    else
    begin
      hiz_src_q <= ir_hiz;
      ext_src_q <= ir_ext;
      if (st == SBT_UPDR && is_bsr)
        upd_tgl_q <= !upd_tgl_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hiz_s_q <= 2'h0;
      ext_s_q <= 2'h0;
      upd_s_q <= 3'h0;
      hiz_q   <= 1'b0;
      ext_q   <= 1'b0;
      drv_q   <= '0;
    end
    else if (i_ce)
    begin
      hiz_s_q <= {hiz_s_q[0], hiz_src_q};
      ext_s_q <= {ext_s_q[0], ext_src_q};
      upd_s_q <= {upd_s_q[1:0], upd_tgl_q};
      hiz_q   <= hiz_s_q[1]; // [R20]
      ext_q   <= ext_s_q[1];
      if (ext_s_q[1] && (!ext_q || (upd_s_q[2] != upd_s_q[1])))
        drv_q <= bsr_upd_q;
    end
  end

  assign o_tdo         = tdo_q;
  assign o_tdo_oe      = tdo_oe_q;
  assign o_mem_out_hiz = hiz_q;
  assign o_extest      = ext_q;
  assign o_bsr_drive   = drv_q;
endmodule : sbt_tap
`default_nettype wire

// ### sim/sbt_jtag_host.sv
// Model of the external test controller: test clock, mode select and serial in.
// Assumes the test clock idles high between frames; undriven lines read as one.
`timescale 1ns/1ps
`default_nettype none
module sbt_jtag_host (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial {o_tck, o_tms, o_tdi} = 3'h7;
  // One test clock period; the returned bit is the output seen at its rising edge.
  task automatic cyc(input logic tms, input logic tdi, output logic tdo);
    #1 o_tms = tms;
    o_tdi = tdi;
    #31 o_tck = 1'b0;
    #32 o_tck = 1'b1;
    tdo = i_tdo;
  endtask : cyc
  task automatic tlr();
    logic t;
    repeat (8) cyc(1'b1, 1'b1, t);
    cyc(1'b0, 1'b1, t);
  endtask : tlr
  // From idle, one register scan of n bits, least significant bit first.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    cyc(1'b1, 1'b1, t);
    if (ir)
      cyc(1'b1, 1'b1, t);
    cyc(1'b0, 1'b1, t);
    cyc(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++)
      cyc(i == n - 1, din[i], dout[i]);
    cyc(1'b1, 1'b1, t);
    cyc(1'b0, 1'b1, t);
  endtask : scan
endmodule : sbt_jtag_host
`default_nettype wire

// ### sim/sbt_tap_assertions.sv
// Checker of the serial output enable and the instruction mode outputs.
// Assumes it is bound to the test port and sampled on the test clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_assertions (
  input wire logic i_rst_b,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic o_tdo_oe,
  input wire logic o_mem_out_hiz,
  input wire logic o_extest
);
  default clocking @(posedge i_tck); endclocking
  default disable iff (!i_rst_b);
  property p_tlr; i_tms [*5] |-> !o_tdo_oe; endproperty
  a_tlr: assert property (p_tlr) else $error("enable after five ones");
  property p_rise; $rose(o_tdo_oe) |-> !$past(i_tms); endproperty
  a_rise: assert property (p_rise) else $error("enable rose wrongly");
  property p_exit; o_tdo_oe && i_tms |=> !o_tdo_oe; endproperty
  a_exit: assert property (p_exit) else $error("enable held on exit");
  property p_hold; o_tdo_oe && !i_tms |=> o_tdo_oe; endproperty
  a_hold: assert property (p_hold) else $error("enable dropped in shift");
  property p_none; !o_tdo_oe && i_tms |=> !o_tdo_oe; endproperty
  a_none: assert property (p_none) else $error("enable on a one");
  property p_dr; i_tms [*5] ##1 !i_tms ##1 i_tms ##1 !i_tms [*2] |=> o_tdo_oe; endproperty
  a_dr: assert property (p_dr) else $error("no data shift");
  property p_ir; i_tms [*5] ##1 !i_tms ##1 i_tms [*2] ##1 !i_tms [*2] |=> o_tdo_oe; endproperty
  a_ir: assert property (p_ir) else $error("no instruction shift");
  property p_idle; i_tms [*8] |-> ##3 !o_mem_out_hiz && !o_extest; endproperty
  a_idle: assert property (p_idle) else $error("mode kept in reset");
endmodule : sbt_tap_assertions
bind sbt_tap sbt_tap_assertions i_chk (.i_rst_b, .i_tck, .i_tms, .o_tdo_oe, .o_mem_out_hiz,
  .o_extest);
`default_nettype wire

// ### sim/tb_sbt_tap.sv
// Self-checking bench of the test port driven by the controller model.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_params.svh"
`define SBT_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb_sbt_tap;
  logic                     i_ref_clk, i_rst_b, tck, tms, tdi, tdo, oe, hiz, ext, t;
  logic [`SBT_BSR_PINS-1:0] pins;
  logic [`SBT_BSR_PINS-1:0] drv;
  logic [31:0]              din, dout;
  logic [8:0]               seq = 9'b0_1111_1001;
  int                       errors = 0, num_checks = 0, cycles = 0;
  sbt_jtag_host i_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  sbt_tap i_dut (.i_ref_clk, .i_rst_b, .i_ce(1'b1), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_pins(pins), .o_tdo(tdo), .o_tdo_oe(oe), .o_mem_out_hiz(hiz), .o_extest(ext),
    .o_bsr_drive(drv));
  function automatic logic [31:0] exp_dr(logic [2:0] c, logic [31:0] d, logic [7:0] p);
    if (c == `SBT_IR_IDCODE)
      return `SBT_ID_CODE;
    if (c == `SBT_IR_EXTEST || c == `SBT_IR_SAMPLE_Z || c == `SBT_IR_PRELOAD)
      return {d[21:0], 2'b11, p};
    return {d[30:0], 1'b0};
  endfunction : exp_dr
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    i_rst_b = 1'b0;
    pins = '0;
    void'($urandom(32'h52B0));
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge i_ref_clk);
      #1 pins = $urandom;
      din = $urandom;
      i_host.tlr();
      i_host.scan(1'b1, 3, 32'(c), dout);
      `SBT_CHK("ir_out", 32'h1, dout)
      i_host.scan(1'b0, 32, din, dout);
      `SBT_CHK("dr_out", exp_dr(3'(c), din, pins), dout)
      repeat (6) @(posedge i_ref_clk);
      if (c == 0)
        `SBT_CHK("drive", din[29:22], drv)
      `SBT_CHK("hiz", 3'(c) == `SBT_IR_SAMPLE_Z, hiz)
      `SBT_CHK("extest", 3'(c) == `SBT_IR_EXTEST, ext)
    end
    // Enter data shift with bypass loaded, then leave by five ones.
    for (int i = 0; i < 9; i++)
      i_host.cyc(seq[i], 1'b1, t);
    i_host.scan(1'b0, 32, din, dout);
    `SBT_CHK("id_after_ones", `SBT_ID_CODE, dout)
    tally_and_finish();
  end
endmodule : tb_sbt_tap
`default_nettype wire
